// file: mpbc_pkg.sv
// Constants and types of the multiphase buck control block
package mpbc_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL1 = 8'h00;
    localparam logic [7:0] ADDR_CTRL2 = 8'h01;
    localparam logic [7:0] ADDR_VMAIN = 8'h02;
    localparam logic [7:0] ADDR_VLOW = 8'h03;
    localparam logic [7:0] ADDR_DELAY = 8'h04;
    localparam logic [7:0] ADDR_SCTRL2 = 8'h05;
    localparam logic [7:0] ADDR_SCTRL1 = 8'h08;
    localparam logic [7:0] ADDR_CONFIG = 8'h0B;
    localparam logic [7:0] ADDR_INT_TOP = 8'h0C;
    localparam logic [7:0] ADDR_INT_CLIM = 8'h0D;
    localparam logic [7:0] ADDR_TOP_MASK = 8'h0E;
    localparam logic [7:0] ADDR_LOAD_SEL = 8'h0F;
    localparam logic [7:0] ADDR_LOAD_LO = 8'h10;
    localparam logic [7:0] ADDR_LOAD_HI = 8'h11;
    // ------------------------------------------------------------
    // Field positions and values after reset
    // ------------------------------------------------------------
    localparam int BIT_EN = 0;
    localparam int BIT_PINCTL = 1;
    localparam int BIT_PINSEL = 2;
    localparam int BIT_ROOF = 3;
    localparam int BIT_FORCE_PWM = 4;
    localparam int BIT_FORCE_MP = 5;
    localparam logic [7:0] CTRL1_MASK = 8'h3F;
    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic [7:0] OTP_CTRL1 = 8'h00;
    localparam logic [7:0] OTP_VMAIN = 8'h20;
    localparam logic [7:0] OTP_VLOW = 8'h10;
    localparam logic [7:0] OTP_DELAY = 8'h00;
    localparam logic [2:0] OTP_CLIM = 3'h3;
    localparam logic [7:0] LFSR_SEED = 8'h01;
    // ------------------------------------------------------------
    // Timing and thresholds
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int MEAS_TIME_NS = 50000;
    localparam logic [23:0] MEAS_CYCLES = 24'(MEAS_TIME_NS / CLK_PERIOD_NS);
    localparam int DELAY_STEP_NS = 100000;
    localparam logic [23:0] DELAY_STEP_CYCLES = 24'(DELAY_STEP_NS / CLK_PERIOD_NS);
    localparam logic [3:0] POR_CYCLES = 4'hF;
    localparam logic [3:0] SLEW_STEP_CYCLES = 4'h8;
    localparam logic [7:0] QUARTER_CYCLES = 8'h14;
    localparam logic [9:0] PFM_LIMIT = 10'h014;
    localparam logic [11:0] PHASE_STEP = 12'h064;
    localparam logic [9:0] RESULT_MAX = 10'h3FF;
    typedef enum logic [2:0] {
        MPBC_POR = 3'b001,
        MPBC_OTP = 3'b010,
        MPBC_STANDBY = 3'b100
    } mpbc_state_e;
endpackage

// file: mpbc_sync.sv
// Three-stage synchroniser with agreement filter
`timescale 1ns/1ps
module mpbc_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge clk) begin
                if (rst) begin
                    s1[i] <= 1'b0;
                    s2[i] <= 1'b0;
                    s3[i] <= 1'b0;
                    q[i] <= 1'b0;
                end else begin
                    s1[i] <= d[i];
                    s2[i] <= s1[i];
                    s3[i] <= s2[i];
                    if (s2[i] == s3[i]) begin
                        q[i] <= s3[i];
                    end
                end
            end
        end
    endgenerate
endmodule

// file: mpbc_top.sv
// Control logic of the four-phase step-down regulator
`timescale 1ns/1ps
module mpbc_top #(
    parameter logic [23:0] MEAS_CYCLES = mpbc_pkg::MEAS_CYCLES,
    parameter logic [23:0] DELAY_STEP_CYCLES = mpbc_pkg::DELAY_STEP_CYCLES
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic link_clk,
    input wire logic host_req,
    input wire logic host_write,
    input wire logic [7:0] host_addr,
    input wire logic [7:0] host_wdata,
    output logic host_ready,
    output logic host_done,
    output logic [7:0] host_rdata,
    input wire logic active_low_reset_pin,
    input wire logic analog_supply_ok,
    input wire logic enable_pin_a,
    input wire logic enable_pin_b,
    input wire logic [39:0] core_current,
    input wire logic [3:0] climit_event,
    output logic standby,
    output logic regulator_on,
    output logic [7:0] vout_target,
    output logic pwm_forced,
    output logic all_phases,
    output logic pfm_mode,
    output logic [3:0] phase_active,
    output logic [3:0] phase_pulse,
    output logic [11:0] climit_setting,
    output logic irq_n
);
    // ------------------------------------------------------------
    // Link side of the register access handshake
    // ------------------------------------------------------------
    logic l_rst;
    logic l_busy;
    logic l_req_tog;
    logic l_write;
    logic [7:0] l_addr;
    logic [7:0] l_wdata;
    logic l_ack_f;
    logic l_ack_seen;
    logic s_ack_tog;
    logic [7:0] s_rdata;

    mpbc_sync #(.W(1)) u_lrst (.clk(link_clk), .rst(1'b0), .d(sys_rst), .q(l_rst));
    mpbc_sync #(.W(1)) u_lack (.clk(link_clk), .rst(l_rst), .d(s_ack_tog), .q(l_ack_f));

    assign host_ready = !l_busy;

    always_ff @(posedge link_clk) begin
        if (l_rst) begin
            l_busy <= 1'b0;
            l_req_tog <= 1'b0;
            l_write <= 1'b0;
            l_addr <= 8'h00;
            l_wdata <= 8'h00;
            l_ack_seen <= 1'b0;
            host_done <= 1'b0;
            host_rdata <= 8'h00;
        end else begin
            host_done <= 1'b0;
            if (host_req && !l_busy) begin
                l_busy <= 1'b1;
                l_req_tog <= ~l_req_tog;
                l_write <= host_write;
                l_addr <= host_addr;
                l_wdata <= host_wdata;
            end else if (l_ack_f != l_ack_seen) begin
                l_ack_seen <= l_ack_f;
                l_busy <= 1'b0;
                host_done <= 1'b1;
                host_rdata <= s_rdata;
            end
        end
    end

    // ------------------------------------------------------------
    // Pin and request synchronisation, power-up sequence
    // ------------------------------------------------------------
    logic s_req_f;
    logic s_req_seen;
    logic rstpin_f;
    logic supply_f;
    logic pin_a_f;
    logic pin_b_f;
    logic chip_rst;
    logic [3:0] por_cnt;
    mpbc_pkg::mpbc_state_e state;

    mpbc_sync #(.W(5)) u_ssync (
        .clk(sys_clk),
        .rst(sys_rst),
        .d({l_req_tog, active_low_reset_pin, analog_supply_ok, enable_pin_b, enable_pin_a}),
        .q({s_req_f, rstpin_f, supply_f, pin_b_f, pin_a_f})
    );

    assign chip_rst = sys_rst || !rstpin_f || !supply_f;
    assign standby = (state == mpbc_pkg::MPBC_STANDBY);

    always_ff @(posedge sys_clk) begin
        if (chip_rst) begin
            state <= mpbc_pkg::MPBC_POR;
            por_cnt <= 4'h0;
        end else begin
            case (state)
                mpbc_pkg::MPBC_POR: begin
                    por_cnt <= por_cnt + 4'h1;
                    if (por_cnt == mpbc_pkg::POR_CYCLES) begin
                        state <= mpbc_pkg::MPBC_OTP;
                    end
                end
                mpbc_pkg::MPBC_OTP: state <= mpbc_pkg::MPBC_STANDBY;
                mpbc_pkg::MPBC_STANDBY: state <= mpbc_pkg::MPBC_STANDBY;
                default: state <= mpbc_pkg::MPBC_POR;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    logic [7:0] ctrl1;
    logic [2:0] climit0;
    logic [2:0] slave_climit [3];
    logic [7:0] vmain;
    logic [7:0] vlow;
    logic [7:0] delay_reg;
    logic dither_en;
    logic meas_flag;
    logic meas_mask;
    logic [3:0] climit_flags;
    logic [1:0] load_sel;
    logic [9:0] result;
    logic [23:0] meas_cnt;
    logic [11:0] sum_raw;
    logic [9:0] sat_sum;
    logic [7:0] rd_mux;
    logic [1:0] sidx;
    logic acc_go;
    logic wr_en;
    logic meas_done;

    assign acc_go = (s_req_f != s_req_seen);
    assign wr_en = acc_go && l_write && standby;
    assign sidx = 2'(l_addr - mpbc_pkg::ADDR_SCTRL2);
    assign meas_done = (meas_cnt == 24'h000001);
    // Total of all four cores, clipped at full scale
    assign sum_raw = {2'h0, core_current[9:0]} + {2'h0, core_current[19:10]}
                   + {2'h0, core_current[29:20]} + {2'h0, core_current[39:30]};
    assign sat_sum = (sum_raw > {2'h0, mpbc_pkg::RESULT_MAX}) ? mpbc_pkg::RESULT_MAX
                   : sum_raw[9:0];
    assign climit_setting = {slave_climit[2], slave_climit[1], slave_climit[0], climit0};

    assign rd_mux = (l_addr == mpbc_pkg::ADDR_CTRL1) ? ctrl1
        : (l_addr == mpbc_pkg::ADDR_CTRL2) ? {5'h00, climit0}
        : (l_addr == mpbc_pkg::ADDR_VMAIN) ? vmain
        : (l_addr == mpbc_pkg::ADDR_VLOW) ? vlow
        : (l_addr == mpbc_pkg::ADDR_DELAY) ? delay_reg
        : (l_addr >= mpbc_pkg::ADDR_SCTRL2 && l_addr < mpbc_pkg::ADDR_SCTRL1)
            ? {5'h00, slave_climit[sidx]}
        : (l_addr == mpbc_pkg::ADDR_CONFIG) ? {7'h00, dither_en}
        : (l_addr == mpbc_pkg::ADDR_INT_TOP) ? {7'h00, meas_flag}
        : (l_addr == mpbc_pkg::ADDR_INT_CLIM) ? {4'h0, climit_flags}
        : (l_addr == mpbc_pkg::ADDR_TOP_MASK) ? {7'h00, meas_mask}
        : (l_addr == mpbc_pkg::ADDR_LOAD_SEL) ? {6'h00, load_sel}
        : (l_addr == mpbc_pkg::ADDR_LOAD_LO) ? result[7:0]
        : (l_addr == mpbc_pkg::ADDR_LOAD_HI) ? {6'h00, result[9:8]}
        : 8'h00;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            s_req_seen <= 1'b0;
            s_ack_tog <= 1'b0;
            s_rdata <= 8'h00;
        end else if (acc_go) begin
            s_req_seen <= s_req_f;
            s_ack_tog <= ~s_ack_tog;
            s_rdata <= (l_write || !standby) ? 8'h00 : rd_mux;
        end
    end

    // Slave control-one writes fall through unstored
    always_ff @(posedge sys_clk) begin
        if (chip_rst) begin
            ctrl1 <= mpbc_pkg::REG_RST;
            climit0 <= 3'h0;
            vmain <= mpbc_pkg::REG_RST;
            vlow <= mpbc_pkg::REG_RST;
            delay_reg <= mpbc_pkg::REG_RST;
            dither_en <= 1'b0;
            meas_mask <= 1'b0;
            load_sel <= 2'h0;
        end else if (state == mpbc_pkg::MPBC_OTP) begin
            ctrl1 <= mpbc_pkg::OTP_CTRL1;
            climit0 <= mpbc_pkg::OTP_CLIM;
            vmain <= mpbc_pkg::OTP_VMAIN;
            vlow <= mpbc_pkg::OTP_VLOW;
            delay_reg <= mpbc_pkg::OTP_DELAY;
        end else if (wr_en) begin
            if (l_addr == mpbc_pkg::ADDR_CTRL1) ctrl1 <= l_wdata & mpbc_pkg::CTRL1_MASK;
            if (l_addr == mpbc_pkg::ADDR_CTRL2) climit0 <= l_wdata[2:0];
            if (l_addr == mpbc_pkg::ADDR_VMAIN) vmain <= l_wdata;
            if (l_addr == mpbc_pkg::ADDR_VLOW) vlow <= l_wdata;
            if (l_addr == mpbc_pkg::ADDR_DELAY) delay_reg <= l_wdata;
            if (l_addr == mpbc_pkg::ADDR_CONFIG) dither_en <= l_wdata[0];
            if (l_addr == mpbc_pkg::ADDR_TOP_MASK) meas_mask <= l_wdata[0];
            if (l_addr == mpbc_pkg::ADDR_LOAD_SEL) load_sel <= l_wdata[1:0];
        end
    end

    genvar k;
    generate
        for (k = 0; k < 3; k++) begin : g_slave
            always_ff @(posedge sys_clk) begin
                if (chip_rst) begin
                    slave_climit[k] <= 3'h0;
                end else if (state == mpbc_pkg::MPBC_OTP) begin
                    slave_climit[k] <= mpbc_pkg::OTP_CLIM;
                end else if (wr_en && l_addr == mpbc_pkg::ADDR_SCTRL2 + 8'(k)) begin
                    slave_climit[k] <= l_wdata[2:0];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Load current measurement and event flags
    // ------------------------------------------------------------
    logic next_meas_flag;
    logic [3:0] next_climit_flags;
    logic meas_clr;
    logic [3:0] climit_clr;

    assign meas_clr = wr_en && l_addr == mpbc_pkg::ADDR_INT_TOP && l_wdata[0];
    assign climit_clr = (wr_en && l_addr == mpbc_pkg::ADDR_INT_CLIM) ? l_wdata[3:0] : 4'h0;
    // Set wins over a clear in the same cycle
    assign next_meas_flag = meas_done || (meas_flag && !meas_clr);
    assign next_climit_flags = climit_event | (climit_flags & ~climit_clr);
    assign irq_n = !((meas_flag && !meas_mask) || (climit_flags != 4'h0));

    always_ff @(posedge sys_clk) begin
        if (chip_rst) begin
            meas_cnt <= 24'h000000;
            result <= 10'h000;
            meas_flag <= 1'b0;
            climit_flags <= 4'h0;
        end else begin
            meas_flag <= next_meas_flag;
            climit_flags <= next_climit_flags;
            if (wr_en && l_addr == mpbc_pkg::ADDR_LOAD_SEL) begin
                meas_cnt <= MEAS_CYCLES;
            end else if (meas_done) begin
                meas_cnt <= 24'h000000;
                result <= sat_sum;
            end else if (meas_cnt != 24'h000000) begin
                meas_cnt <= meas_cnt - 24'h000001;
            end
        end
    end

    // ------------------------------------------------------------
    // Enable source selection and pin delays
    // ------------------------------------------------------------
    logic pin_lvl;
    logic pin_prev;
    logic pin_on;
    logic pin_pend;
    logic [23:0] del_cnt;
    logic [23:0] del_cycles;
    logic pin_edge;
    logic req_on;
    logic [7:0] want_v;
    logic [3:0] slew_cnt;
    logic slewing;

    assign pin_lvl = ctrl1[mpbc_pkg::BIT_PINSEL] ? pin_b_f : pin_a_f;
    assign pin_edge = (pin_lvl != pin_prev);
    assign del_cycles = pin_lvl ? 24'(delay_reg[3:0] * DELAY_STEP_CYCLES)
                      : 24'(delay_reg[7:4] * DELAY_STEP_CYCLES);
    assign req_on = standby && ctrl1[mpbc_pkg::BIT_EN]
        && (!ctrl1[mpbc_pkg::BIT_PINCTL] || ctrl1[mpbc_pkg::BIT_ROOF] || pin_on);
    assign want_v = (ctrl1[mpbc_pkg::BIT_PINCTL] && ctrl1[mpbc_pkg::BIT_ROOF] && !pin_lvl)
                  ? vlow : vmain;
    assign slewing = regulator_on && (vout_target != want_v);

    always_ff @(posedge sys_clk) begin
        if (chip_rst) begin
            pin_prev <= 1'b0;
            pin_on <= 1'b0;
            pin_pend <= 1'b0;
            del_cnt <= 24'h000000;
        end else begin
            pin_prev <= pin_lvl;
            if (pin_edge && del_cycles == 24'h000000) begin
                pin_on <= pin_lvl;
                del_cnt <= 24'h000000;
            end else if (pin_edge) begin
                pin_pend <= pin_lvl;
                del_cnt <= del_cycles;
            end else if (del_cnt == 24'h000001) begin
                pin_on <= pin_pend;
                del_cnt <= 24'h000000;
            end else if (del_cnt != 24'h000000) begin
                del_cnt <= del_cnt - 24'h000001;
            end
        end
    end

    // Register enable bypasses the pin delay path
    always_ff @(posedge sys_clk) begin
        if (chip_rst) begin
            regulator_on <= 1'b0;
            vout_target <= 8'h00;
            slew_cnt <= 4'h0;
        end else begin
            regulator_on <= req_on;
            if (!regulator_on) begin
                vout_target <= want_v;
                slew_cnt <= 4'h0;
            end else if (slewing && slew_cnt == mpbc_pkg::SLEW_STEP_CYCLES) begin
                vout_target <= (vout_target < want_v) ? vout_target + 8'h01
                             : vout_target - 8'h01;
                slew_cnt <= 4'h0;
            end else if (slewing) begin
                slew_cnt <= slew_cnt + 4'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // Mode, phase count and interleaved phase timing
    // ------------------------------------------------------------
    logic force_mp;
    logic light;
    logic [3:0] next_active;
    logic [7:0] q_cnt;
    logic [7:0] q_len;
    logic [1:0] q_idx;
    logic [7:0] lfsr;

    assign force_mp = ctrl1[mpbc_pkg::BIT_FORCE_MP];
    assign light = sat_sum < mpbc_pkg::PFM_LIMIT;
    assign next_active = (force_mp || sum_raw >= 12'(3 * mpbc_pkg::PHASE_STEP)) ? 4'hF
        : (sum_raw >= 12'(2 * mpbc_pkg::PHASE_STEP)) ? 4'h7
        : (sum_raw >= mpbc_pkg::PHASE_STEP) ? 4'h3 : 4'h1;
    assign q_len = !dither_en ? mpbc_pkg::QUARTER_CYCLES
        : lfsr[0] ? mpbc_pkg::QUARTER_CYCLES + 8'h01
        : lfsr[1] ? mpbc_pkg::QUARTER_CYCLES - 8'h01 : mpbc_pkg::QUARTER_CYCLES;

    always_ff @(posedge sys_clk) begin
        if (chip_rst) begin
            pwm_forced <= 1'b0;
            all_phases <= 1'b0;
            pfm_mode <= 1'b0;
            phase_active <= 4'h0;
        end else begin
            pwm_forced <= force_mp || ctrl1[mpbc_pkg::BIT_FORCE_PWM] || slewing;
            all_phases <= force_mp && req_on;
            pfm_mode <= req_on && !force_mp && !ctrl1[mpbc_pkg::BIT_FORCE_PWM]
                        && !slewing && light;
            phase_active <= !req_on ? 4'h0
                : (light && !force_mp && !slewing) ? 4'h1 : next_active;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (chip_rst) begin
            q_cnt <= 8'h00;
            q_idx <= 2'h0;
            lfsr <= mpbc_pkg::LFSR_SEED;
            phase_pulse <= 4'h0;
        end else begin
            phase_pulse <= 4'h0;
            lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
            if (q_cnt == 8'h00) begin
                q_cnt <= q_len - 8'h01;
                q_idx <= q_idx + 2'h1;
                phase_pulse[q_idx] <= regulator_on && !pfm_mode && phase_active[q_idx];
            end else begin
                q_cnt <= q_cnt - 8'h01;
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (chip_rst);

    AST_FORCE_MP: assert property (all_phases |-> pwm_forced && phase_active == 4'hF)
        else $error("forced multi-phase without all phases in PWM");
    AST_PFM_AUTO: assert property (pfm_mode |-> !pwm_forced && phase_active == 4'h1)
        else $error("PFM while PWM forced");
    AST_SLAVE_IGN: assert property (wr_en && l_addr == mpbc_pkg::ADDR_SCTRL1
        |=> $stable(ctrl1))
        else $error("slave control write changed master control");
    AST_MEAS_START: assert property (wr_en && l_addr == mpbc_pkg::ADDR_LOAD_SEL
        |=> meas_cnt == MEAS_CYCLES)
        else $error("measurement did not start");
    AST_MEAS_DONE: assert property ($rose(meas_flag) |-> $past(meas_cnt) == 24'h000001
        && result == $past(sat_sum))
        else $error("ready flag without finished measurement");
    AST_IRQ_MASK: assert property (meas_mask && climit_flags == 4'h0 |-> irq_n)
        else $error("masked ready flag drove interrupt");
    AST_STANDBY_EN: assert property (!standby |=> !regulator_on)
        else $error("regulator on outside standby");
    AST_REG_EN: assert property (standby && ctrl1[0] && !ctrl1[1] |=> regulator_on)
        else $error("register enable not immediate");
    AST_PIN_OFF: assert property (ctrl1[1] && !ctrl1[3] && !pin_on |=> !regulator_on)
        else $error("pin mode enabled while pin off");
    AST_ROOF: assert property (standby && ctrl1[0] && ctrl1[1] && ctrl1[3]
        |=> regulator_on)
        else $error("two-level mode disabled output");
    AST_INTERLEAVE: assert property (phase_pulse[0] && !dither_en && phase_active == 4'hF
        && !pfm_mode |-> ##20 (phase_pulse[1] || dither_en || phase_active != 4'hF))
        else $error("phase spacing not a quarter period");

    COV_MEAS: cover property ($rose(meas_flag));
    COV_ROOF_LOW: cover property (regulator_on && ctrl1[3] && vout_target == vlow);
    COV_PIN_DELAY: cover property ($rose(pin_on) && del_cycles != 24'h000000);
    COV_SLEW: cover property (slewing ##1 !slewing);
endmodule

// file: mpbc_host.sv
// Host model driving the register access port
`timescale 1ns/1ps
module mpbc_host (
    input wire logic link_clk,
    input wire logic host_ready,
    input wire logic host_done,
    input wire logic [7:0] host_rdata,
    output logic host_req,
    output logic host_write,
    output logic [7:0] host_addr,
    output logic [7:0] host_wdata
);
    int lost = 0;
    initial begin
        host_req = 1'b0;
        host_write = 1'b0;
        host_addr = 8'h00;
        host_wdata = 8'h00;
    end
    // One access; ready is high while idle, so the request is taken at once
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
        output logic [7:0] q);
        @(posedge link_clk);
        host_req <= 1'b1;
        host_write <= w;
        host_addr <= a;
        host_wdata <= d;
        @(posedge link_clk);
        host_req <= 1'b0;
        for (int i = 0; i < 300; i++) begin
            @(posedge link_clk);
            #1;
            if (host_done === 1'b1) break;
        end
        if (host_done !== 1'b1) lost++;
        q = host_rdata;
    endtask
endmodule

// file: tb_top.sv
// Self-checking bench of the buck control block
`timescale 1ns/1ps
module tb_top;
    logic sys_clk = 1'b0, sys_rst = 1'b1, link_clk = 1'b0, pin_a = 1'b0;
    logic host_req, host_write, host_ready, host_done, regulator_on, pwm_forced;
    logic all_phases, irq_n, standby, pfm, rst_pin = 1'b1, supply_ok = 1'b1, pin_b = 1'b0;
    logic [7:0] host_addr, host_wdata, host_rdata, vout_target, q, dv;
    logic [3:0] phase_active, pulse, clim_ev = 4'h0;
    logic [11:0] clim;
    logic [39:0] core_current = {10'h032, 10'h12C, 10'h0C8, 10'h064};
    int error_cnt = 0, tests_run = 0;
    always #5 sys_clk = ~sys_clk;
    initial begin
        #1.7;
        forever #3 link_clk = ~link_clk;
    end
    mpbc_top #(.MEAS_CYCLES(24'h000014), .DELAY_STEP_CYCLES(24'h000004)) dut_u (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .link_clk(link_clk),
        .host_req(host_req), .host_write(host_write), .host_addr(host_addr),
        .host_wdata(host_wdata), .host_ready(host_ready), .host_done(host_done),
        .host_rdata(host_rdata), .active_low_reset_pin(rst_pin), .analog_supply_ok(supply_ok),
        .enable_pin_a(pin_a), .enable_pin_b(pin_b), .core_current(core_current),
        .climit_event(clim_ev), .standby(standby), .regulator_on(regulator_on),
        .vout_target(vout_target), .pwm_forced(pwm_forced), .all_phases(all_phases),
        .pfm_mode(pfm), .phase_active(phase_active), .phase_pulse(pulse),
        .climit_setting(clim), .irq_n(irq_n));
    mpbc_host host_u (.link_clk(link_clk), .host_ready(host_ready),
        .host_done(host_done), .host_rdata(host_rdata), .host_req(host_req),
        .host_write(host_write), .host_addr(host_addr), .host_wdata(host_wdata));
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host_u.xfer(1'b1, a, d, q);
        cyc(4);
    endtask
    task automatic rd(input logic [7:0] a);
        host_u.xfer(1'b0, a, 8'h00, q);
    endtask
    // Cycles from a phase 0 start to the next phase 1 start
    task automatic gap(output logic [7:0] g);
        g = 8'h00;
        for (int i = 0; i < 100 && pulse[0] !== 1'b1; i++) cyc(1);
        do begin
            cyc(1);
            g++;
        end while (pulse[1] !== 1'b1 && g < 8'h40);
    endtask
    task automatic wait_sb();
        for (int i = 0; i < 200 && standby !== 1'b1; i++) cyc(1);
        chk("standby", 8'h01, {7'h00, standby});
    endtask
    task automatic final_report();
        error_cnt += host_u.lost;
        $display("Checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #200000;
        error_cnt++;
        final_report();
    end
    initial begin
        repeat (10) @(posedge sys_clk);
        sys_rst <= 1'b0;
        wait_sb();
        rd(mpbc_pkg::ADDR_VMAIN);
        chk("vmain", mpbc_pkg::OTP_VMAIN, q);
        wr(mpbc_pkg::ADDR_CTRL1, 8'h01);
        chk("on_reg", 8'h01, {7'h00, regulator_on});
        wr(mpbc_pkg::ADDR_CTRL1, 8'h03);
        cyc(10);
        chk("off_pin", 8'h00, {7'h00, regulator_on});
        @(posedge sys_clk) pin_a <= 1'b1;
        cyc(20);
        chk("on_pin", 8'h01, {7'h00, regulator_on});
        wr(mpbc_pkg::ADDR_CTRL1, 8'h0B);
        @(posedge sys_clk) pin_a <= 1'b0;
        cyc(300);
        chk("floor_on", 8'h01, {7'h00, regulator_on});
        chk("floor_v", mpbc_pkg::OTP_VLOW, vout_target);
        wr(mpbc_pkg::ADDR_CTRL1, 8'h21);
        cyc(10);
        chk("force_mp", 8'h0F, {phase_active[3:2], all_phases, pwm_forced});
        wr(mpbc_pkg::ADDR_SCTRL1, 8'h3F);
        rd(mpbc_pkg::ADDR_SCTRL1);
        chk("slave_ctl", 8'h00, q);
        wr(mpbc_pkg::ADDR_LOAD_SEL, 8'h02);
        cyc(40);
        rd(mpbc_pkg::ADDR_INT_TOP);
        chk("ready", 8'h01, {7'h00, q[0]});
        chk("irq_on", 8'h00, {7'h00, irq_n});
        wr(mpbc_pkg::ADDR_TOP_MASK, 8'h01);
        chk("irq_mask", 8'h01, {7'h00, irq_n});
        rd(mpbc_pkg::ADDR_LOAD_LO);
        chk("res_lo", 8'h8A, q);
        rd(mpbc_pkg::ADDR_LOAD_HI);
        chk("res_hi", 8'h02, {6'h00, q[1:0]});
        @(posedge sys_clk) clim_ev <= 4'h2;
        @(posedge sys_clk) clim_ev <= 4'h0;
        cyc(1);
        chk("irq_clim", 8'h00, {7'h00, irq_n});
        rd(mpbc_pkg::ADDR_INT_CLIM);
        chk("clim_flag", 8'h02, q);
        wr(mpbc_pkg::ADDR_INT_CLIM, 8'h02);
        chk("irq_clr", 8'h01, {7'h00, irq_n});
        wr(mpbc_pkg::ADDR_SCTRL2 + 8'h01, 8'h05);
        chk("clim_set", 8'h75, clim[11:4]);
        wr(mpbc_pkg::ADDR_CTRL1, 8'h01);
        @(posedge sys_clk) core_current <= {10'h000, 10'h000, 10'h000, 10'h096};
        cyc(150);
        chk("phase_mid", 8'h03, {3'h0, pfm, phase_active});
        @(posedge sys_clk) core_current <= {10'h004, 10'h004, 10'h004, 10'h004};
        cyc(4);
        chk("pfm", 8'h11, {3'h0, pfm, phase_active});
        wr(mpbc_pkg::ADDR_DELAY, 8'h23);
        wr(mpbc_pkg::ADDR_CTRL1, 8'h07);
        @(posedge sys_clk) pin_b <= 1'b1;
        cyc(12);
        chk("on_wait", 8'h00, {7'h00, regulator_on});
        cyc(10);
        chk("on_late", 8'h01, {7'h00, regulator_on});
        @(posedge sys_clk) pin_b <= 1'b0;
        cyc(6);
        chk("off_wait", 8'h01, {7'h00, regulator_on});
        cyc(12);
        chk("off_late", 8'h00, {7'h00, regulator_on});
        wr(mpbc_pkg::ADDR_CTRL1, 8'h21);
        gap(q);
        chk("gap", mpbc_pkg::QUARTER_CYCLES, q);
        wr(mpbc_pkg::ADDR_CONFIG, 8'h01);
        dv = 8'h00;
        for (int i = 0; i < 8; i++) begin
            gap(q);
            if (q < 8'h13 || q > 8'h15) dv[7] = 1'b1;
            if (q != mpbc_pkg::QUARTER_CYCLES) dv[0] = 1'b1;
        end
        chk("gap_dither", 8'h01, dv);
        for (int j = 0; j < 2; j++) begin
            wr(mpbc_pkg::ADDR_VMAIN, 8'h30);
            @(posedge sys_clk) {rst_pin, supply_ok} <= (j == 0) ? 2'b01 : 2'b10;
            cyc(8);
            chk("rst_off", 8'h00, {6'h00, standby, regulator_on});
            @(posedge sys_clk) {rst_pin, supply_ok} <= 2'b11;
            wait_sb();
            rd(mpbc_pkg::ADDR_VMAIN);
            chk("rst_vmain", mpbc_pkg::OTP_VMAIN, q);
        end
        final_report();
    end
endmodule
